/* pxc_pkg.sv */
// Purpose: Shared constants for the port and external interrupt block
// Assumes: 32-bit APB register bus, 100 MHz pclk
// Notes:   Offsets are byte addresses
package pxc_pkg;
   // Timing
   localparam int CLK_NS       = 10;
   localparam int BOOT_NS      = 3_000_000;
   localparam int BOOT_CYC_DEF = BOOT_NS / CLK_NS;
   localparam int FILT_FAST    = 2;
   localparam int FILT_SLOW    = 32;
   // Memory map of the core
   localparam logic [15:0] OPT_BASE   = 16'h7F00;
   localparam logic [15:0] OPT_TOP    = 16'h7FFF;
   localparam logic [15:0] PROG_TOP   = 16'h7EFF;
   localparam int          PROG_BYTES = 32512;
   localparam logic [15:0] RESET_PC   = 16'h0000;
   localparam logic [2:0]  OPT_NBYTES = 3'h4;
   // Option byte slots inside the option area
   localparam logic [1:0] OPT_PA_PU = 2'h0;
   localparam logic [1:0] OPT_PA_OD = 2'h1;
   localparam logic [1:0] OPT_PB_OD = 2'h2;
   localparam logic [1:0] OPT_PC_PU = 2'h3;
   localparam logic [3:0] PC_PU_RST = 4'hF;
   // Interrupt vectors
   localparam logic [7:0] VEC_A = 8'h03;
   localparam logic [7:0] VEC_B = 8'h0B;
   localparam logic [7:0] VEC_C = 8'h13;
   localparam logic [7:0] VEC_D = 8'h1B;
   // Register offsets
   localparam logic [7:0] REG_PA_CTRL  = 8'h00;
   localparam logic [7:0] REG_PB_DIR   = 8'h04;
   localparam logic [7:0] REG_PB_OUT   = 8'h08;
   localparam logic [7:0] REG_PB_PULL  = 8'h0C;
   localparam logic [7:0] REG_PB_ALT   = 8'h10;
   localparam logic [7:0] REG_PC_OUT   = 8'h14;
   localparam logic [7:0] REG_IRQ_CFG  = 8'h18;
   localparam logic [7:0] REG_IRQ_PEND = 8'h1C;
   localparam logic [7:0] REG_PIN_IN   = 8'h20;
   localparam logic [7:0] REG_STATUS   = 8'h24;
   // Field positions of IRQ_CFG
   localparam int CFG_EN_LSB = 8;
   localparam int CFG_SLOW   = 12;
   // Detection modes
   typedef enum logic [1:0] {
      MODE_RISE = 2'b00,
      MODE_FALL = 2'b01,
      MODE_HIGH = 2'b10,
      MODE_LOW  = 2'b11
   } pxc_mode_t;
   localparam logic [1:0] MODE_BOTH = 2'b10;
endpackage

/* pxc_port_irq.sv */
// Purpose: Port pin configuration, option loading and external interrupts
// Assumes: Pins synchronous to pclk; option memory answers in the same cycle its read strobe is high
// Notes:   Registers reached over APB, one word each
// Functional notes
// - After reset, load options for up to 3 ms, then fetch from 0000H.
// - Top 256 bytes 7F00H-7FFFH hold option data, not program.
// - Program space is 32512 bytes, 0000H to 7EFFH.
// - Inputs a and b detect rise, fall, high, low; never both edges.
// - Input c detects rise, fall or both edges; vector 13H.
// - Input d detects rise, fall or both edges; vector 1BH.
// - Port a inputs, pull-ups off in reset; option pull-ups on after.
// - Port b inputs with programmable pull-ups off during reset.
// - Port c inputs during reset with option pull-ups fixed on.
// - Port a direction set per nibble.
// - Port b direction set per bit.
// - Pull-up and CMOS or open-drain format chosen per pin.
// - Port a CMOS output pins have their pull-up provided.
// - Port b programmable pull-up works with either output format.
// - Port b alternates: serial out, serial in/bus, serial clock, timer 1 PWM.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pxc_port_irq
   import pxc_pkg::*;
#(
   parameter int unsigned BOOT_CYC = BOOT_CYC_DEF
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  port_a_pins_in,
   output logic      [7:0]  port_a_pins_out,
   output logic      [7:0]  port_a_pins_oe,
   output logic      [7:0]  port_a_pull,
   input  wire logic [7:0]  port_b_pins_in,
   output logic      [7:0]  port_b_pins_out,
   output logic      [7:0]  port_b_pins_oe,
   output logic      [7:0]  port_b_pull,
   input  wire logic [3:0]  port_c_in,
   output logic             port_c_bit0_out,
   output logic             port_c_bit0_oe,
   output logic      [3:0]  port_c_pull,
   output logic      [15:0] opt_addr,
   output logic             opt_rd,
   input  wire logic [7:0]  opt_data,
   output logic             fetch_en,
   output logic      [15:0] fetch_addr,
   input  wire logic [15:0] core_addr,
   output logic             core_addr_bad,
   output logic      [3:0]  irq_pend,
   output logic             irq_req,
   output logic      [7:0]  irq_vec,
   output logic             timer0_event_in,
   input  wire logic        hold_mode,
   output logic             hold_wake,
   input  wire logic        sio_dout,
   input  wire logic        sio_data_oe,
   input  wire logic        sio_clk_out,
   input  wire logic        sio_clk_oe,
   input  wire logic        pwm1_out,
   output logic             sio_din,
   output logic             sio_clk_in
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0]  pa_out;
      logic [1:0]  pa_dir;
      logic [7:0]  pb_dir;
      logic [7:0]  pb_out;
      logic [7:0]  pb_pull;
      logic [3:0]  pb_alt;
      logic        pc_out;
      logic [12:0] icfg;
      logic [3:0]  pend;
      logic [3:0]  pc_prev;
      logic        dfilt;
      logic [4:0]  fcnt;
      logic        boot;
      logic [19:0] bcnt;
      logic [2:0]  oidx;
      logic [7:0]  o_pa_pu;
      logic [7:0]  o_pa_od;
      logic [7:0]  o_pb_od;
      logic [3:0]  o_pc_pu;
      logic [7:0]  pa_o;
      logic [7:0]  pa_e;
      logic [7:0]  pa_p;
      logic [7:0]  pb_o;
      logic [7:0]  pb_e;
      logic [7:0]  pb_p;
      logic [3:0]  pc_p;
      logic        pc0_e;
      logic [15:0] opt_a;
      logic        opt_rd;
      logic        bad;
      logic        req;
      logic [7:0]  vec;
      logic        t0ev;
      logic        wake;
      logic        sdin;
      logic        scki;
      logic [31:0] rdata;
      logic        rdy;
      logic        err;
   } pxc_state_t;
   pxc_state_t s_r;
   pxc_state_t s_nxt;
   ////////////////////////////////////////////////////////////////////////
   // Edge and level detectors
   function automatic logic det4(input logic [1:0] m, input logic p, input logic c);
      case (m)
         MODE_RISE: det4 = ~p & c;
         MODE_FALL: det4 = p & ~c;
         MODE_HIGH: det4 = c;
         default:   det4 = ~c;
      endcase
   endfunction
   function automatic logic det3(input logic [1:0] m, input logic p, input logic c);
      case (m)
         MODE_RISE: det3 = ~p & c;
         MODE_FALL: det3 = p & ~c;
         MODE_BOTH: det3 = p ^ c;
         default:   det3 = 1'b0;
      endcase
   endfunction
   function automatic logic in_prog(input logic [15:0] a);
      in_prog = (a <= PROG_TOP);
   endfunction
   ////////////////////////////////////////////////////////////////////////
   logic [3:0] evt;
   logic [3:0] en;
   logic       setup;
   logic       wr;
   logic [4:0] fneed;
   logic [7:0] pb_src;
   logic [7:0] pb_drv;
   logic [3:0] live;
   always_comb begin
      s_nxt = s_r;
      en    = s_r.icfg[CFG_EN_LSB +: 4];
      setup = psel & ~penable;
      wr    = psel & penable & s_r.rdy & pwrite;
      // Option loader: fixed-length load window, then fetch from the reset vector
      if (!s_r.boot) begin
         s_nxt.bcnt = s_r.bcnt + 20'h0_0001;
         if (s_r.oidx < OPT_NBYTES) begin
            s_nxt.opt_rd = 1'b1;
            s_nxt.opt_a  = OPT_BASE + {13'h0000, s_r.oidx};
            s_nxt.oidx   = s_r.oidx + 3'h1;
         end else begin
            s_nxt.opt_rd = 1'b0;
         end
         if (s_r.opt_rd) begin
            case (s_r.opt_a[1:0])
               OPT_PA_PU: s_nxt.o_pa_pu = opt_data;
               OPT_PA_OD: s_nxt.o_pa_od = opt_data;
               OPT_PB_OD: s_nxt.o_pb_od = opt_data;
               default:   s_nxt.o_pc_pu = opt_data[3:0];
            endcase
         end
         if (s_r.bcnt >= BOOT_CYC[19:0] - 20'h0_0001 && s_r.oidx == OPT_NBYTES && !s_r.opt_rd) begin
            s_nxt.boot = 1'b1;
         end
      end
      s_nxt.bad = ~in_prog(core_addr);
      // Noise filter on input d
      fneed = s_r.icfg[CFG_SLOW] ? 5'(FILT_SLOW - 1) : 5'(FILT_FAST - 1);
      if (port_c_in[3] != s_r.dfilt) begin
         if (s_r.fcnt >= fneed) begin
            s_nxt.dfilt = port_c_in[3];
            s_nxt.fcnt  = 5'h00;
         end else begin
            s_nxt.fcnt = s_r.fcnt + 5'h01;
         end
      end else begin
         s_nxt.fcnt = 5'h00;
      end
      s_nxt.pc_prev = port_c_in;
      evt[0] = det4(s_r.icfg[1:0], s_r.pc_prev[0], port_c_in[0]);
      evt[1] = det4(s_r.icfg[3:2], s_r.pc_prev[1], port_c_in[1]);
      evt[2] = det3(s_r.icfg[5:4], s_r.pc_prev[2], port_c_in[2]);
      evt[3] = det3(s_r.icfg[7:6], s_r.dfilt, s_nxt.dfilt);
      s_nxt.t0ev = s_r.pc_prev[2] ^ port_c_in[2];
      s_nxt.wake = hold_mode & evt[1];
      // Pending flags: acknowledge by write-one-to-clear, a new event wins
      s_nxt.pend = s_r.pend;
      if (wr && paddr == REG_IRQ_PEND) begin
         s_nxt.pend = s_r.pend & ~pwdata[3:0];
      end
      s_nxt.pend = s_nxt.pend | (evt & en);
      live       = s_nxt.pend & en;
      s_nxt.req  = |live;
      if (live[0]) begin
         s_nxt.vec = VEC_A;
      end else if (live[1]) begin
         s_nxt.vec = VEC_B;
      end else if (live[2]) begin
         s_nxt.vec = VEC_C;
      end else if (live[3]) begin
         s_nxt.vec = VEC_D;
      end else begin
         s_nxt.vec = 8'h00;
      end
      // Register writes
      if (wr) begin
         case (paddr)
            REG_PA_CTRL: begin
               s_nxt.pa_out = pwdata[7:0];
               s_nxt.pa_dir = pwdata[9:8];
            end
            REG_PB_DIR:  s_nxt.pb_dir  = pwdata[7:0];
            REG_PB_OUT:  s_nxt.pb_out  = pwdata[7:0];
            REG_PB_PULL: s_nxt.pb_pull = pwdata[7:0];
            REG_PB_ALT:  s_nxt.pb_alt  = pwdata[3:0];
            REG_PC_OUT:  s_nxt.pc_out  = pwdata[0];
            REG_IRQ_CFG: s_nxt.icfg    = pwdata[12:0];
            default:     s_nxt.pc_out  = s_r.pc_out;
         endcase
      end
      // Port a: nibble direction, per-bit format and pull-up
      for (int i = 0; i < 8; i++) begin
         s_nxt.pa_e[i] = s_r.pa_dir[i / 4] & (~s_r.o_pa_od[i] | ~s_r.pa_out[i]);
      end
      s_nxt.pa_o = s_r.pa_out & ~s_r.o_pa_od;
      s_nxt.pa_p = s_r.boot ? (s_r.o_pa_pu | ~s_r.o_pa_od) : 8'h00;
      // Port b: alternate functions override the port latch
      pb_src    = s_r.pb_out;
      pb_drv    = s_r.pb_dir;
      if (s_r.pb_alt[0]) begin
         pb_src[0] = sio_dout;
         pb_drv[0] = 1'b1;
      end
      if (s_r.pb_alt[1]) begin
         pb_src[1] = sio_dout;
         pb_drv[1] = sio_data_oe;
      end
      if (s_r.pb_alt[2]) begin
         pb_src[2] = sio_clk_out;
         pb_drv[2] = sio_clk_oe;
      end
      if (s_r.pb_alt[3]) begin
         pb_src[7] = pwm1_out;
         pb_drv[7] = 1'b1;
      end
      s_nxt.pb_e  = pb_drv & (~s_r.o_pb_od | ~pb_src);
      s_nxt.pb_o  = pb_src & ~s_r.o_pb_od;
      s_nxt.pb_p  = s_r.boot ? s_r.pb_pull : 8'h00;
      s_nxt.sdin  = port_b_pins_in[1];
      s_nxt.scki  = port_b_pins_in[2];
      // Port c: bit 0 is open drain, pull-ups hold their reset value until loaded
      s_nxt.pc0_e = ~s_r.pc_out;
      s_nxt.pc_p  = s_r.boot ? s_r.o_pc_pu : s_r.pc_p;
      // APB answer: ready in the first access cycle
      s_nxt.rdy   = setup;
      s_nxt.err   = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      if (setup) begin
         case (paddr)
            REG_PA_CTRL:  s_nxt.rdata = {22'h00_0000, s_r.pa_dir, s_r.pa_out};
            REG_PB_DIR:   s_nxt.rdata = {24'h00_0000, s_r.pb_dir};
            REG_PB_OUT:   s_nxt.rdata = {24'h00_0000, s_r.pb_out};
            REG_PB_PULL:  s_nxt.rdata = {24'h00_0000, s_r.pb_pull};
            REG_PB_ALT:   s_nxt.rdata = {28'h000_0000, s_r.pb_alt};
            REG_PC_OUT:   s_nxt.rdata = {31'h0000_0000, s_r.pc_out};
            REG_IRQ_CFG:  s_nxt.rdata = {19'h0_0000, s_r.icfg};
            REG_IRQ_PEND: s_nxt.rdata = {28'h000_0000, s_r.pend};
            REG_PIN_IN:   s_nxt.rdata = {12'h000, port_c_in, port_b_pins_in, port_a_pins_in};
            REG_STATUS:   s_nxt.rdata = {31'h0000_0000, s_r.boot};
            default:      s_nxt.err   = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r      <= '0;
         s_r.pc_p <= PC_PU_RST;
         s_r.pc_prev <= PC_PU_RST; // Pins idle high under their pull-ups
         s_r.dfilt   <= PC_PU_RST[3];
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign prdata          = s_r.rdata;
   assign pready          = s_r.rdy;
   assign pslverr         = s_r.err;
   assign port_a_pins_out = s_r.pa_o;
   assign port_a_pins_oe  = s_r.pa_e;
   assign port_a_pull     = s_r.pa_p;
   assign port_b_pins_out = s_r.pb_o;
   assign port_b_pins_oe  = s_r.pb_e;
   assign port_b_pull     = s_r.pb_p;
   assign port_c_bit0_out = 1'b0;
   assign port_c_bit0_oe  = s_r.pc0_e;
   assign port_c_pull     = s_r.pc_p;
   assign opt_addr        = s_r.opt_a;
   assign opt_rd          = s_r.opt_rd;
   assign fetch_en        = s_r.boot;
   assign fetch_addr      = RESET_PC;
   assign core_addr_bad   = s_r.bad;
   assign irq_pend        = s_r.pend;
   assign irq_req         = s_r.req;
   assign irq_vec         = s_r.vec;
   assign timer0_event_in = s_r.t0ev;
   assign hold_wake       = s_r.wake;
   assign sio_din         = s_r.sdin;
   assign sio_clk_in      = s_r.scki;

   ////////////////////////////////////////////////////////////////////////
   sequence seq_clear_a;
      psel && penable && pready && pwrite && paddr == REG_IRQ_PEND && pwdata[0];
   endsequence
   sequence seq_boot_wait;
      !s_r.boot ##1 s_r.boot;
   endsequence
   a_boot_fetch: assert property (@(posedge pclk) disable iff (!presetn)
      seq_boot_wait |-> s_r.bcnt >= BOOT_CYC[19:0] && fetch_addr == 16'h0000 && !opt_rd)
      else $error("fetch started before the option load window ended");
   a_opt_area: assert property (@(posedge pclk) disable iff (!presetn)
      opt_rd |-> opt_addr >= OPT_BASE && opt_addr <= OPT_TOP)
      else $error("option read outside the option area");
   a_prog_bad: assert property (@(posedge pclk) disable iff (!presetn)
      core_addr > PROG_TOP |=> core_addr_bad)
      else $error("address above program space not flagged");
   a_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_r.icfg[1:0] == MODE_RISE && en[0] && !s_r.pc_prev[0] && port_c_in[0]) |=> irq_pend[0])
      else $error("rising edge on input a not latched");
   a_vec_c: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_req && irq_vec == VEC_C) |-> irq_pend[2] && (irq_pend[1:0] & s_r.icfg[9:8]) == 2'b00)
      else $error("vector c given without its pending flag");
   a_vec_d: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_req && irq_vec == VEC_D) |-> irq_pend[3] && (irq_pend[2:0] & s_r.icfg[10:8]) == 3'b000)
      else $error("vector d given without its pending flag");
   a_filter_d: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(s_r.dfilt) |-> $past(port_c_in[3]) == s_r.dfilt && $past(port_c_in[3], 2) == s_r.dfilt)
      else $error("filtered input d followed a short pulse");
   a_t0_event: assert property (@(posedge pclk) disable iff (!presetn)
      timer0_event_in |-> $past(port_c_in[2]) != $past(port_c_in[2], 2))
      else $error("timer event without a pin change");
   a_hold_wake: assert property (@(posedge pclk) disable iff (!presetn)
      hold_wake |-> $past(hold_mode))
      else $error("wake raised outside hold");
   a_pa_pull: assert property (@(posedge pclk) disable iff (!presetn)
      !s_r.boot |-> port_a_pull == 8'h00 && port_b_pull == 8'h00)
      else $error("pull-up on before option load finished");
   a_pc_pull: assert property (@(posedge pclk) disable iff (!presetn)
      !s_r.boot |-> port_c_pull == PC_PU_RST)
      else $error("port c pull-up not fixed on during load");
   a_pend_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (seq_clear_a and (!(evt[0] && en[0]))) |=> !irq_pend[0])
      else $error("acknowledged flag a not cleared");
   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("apb answer not one cycle");
endmodule
`default_nettype wire

/* pxc_ext_model.sv */
// Purpose: Far side model: option memory and the circuitry on ports a and b
// Assumes: Option data stands while the read strobe is high
// Notes:   Outside a read the data bus shows the inverse of the last byte
`timescale 1ns/10ps
`default_nettype none
module pxc_ext_model
   import pxc_pkg::*;
#(
   parameter logic [31:0] OPT_WORD = 32'h0500_0F00
) (
   input  wire logic        pclk,
   input  wire logic [15:0] opt_addr,
   input  wire logic        opt_rd,
   output logic      [7:0]  opt_data,
   input  wire logic [7:0]  a_out,
   input  wire logic [7:0]  a_oe,
   input  wire logic [7:0]  a_ext,
   output logic      [7:0]  a_pins,
   input  wire logic [7:0]  b_out,
   input  wire logic [7:0]  b_oe,
   input  wire logic [7:0]  b_ext,
   output logic      [7:0]  b_pins
);
   logic [7:0] last = 8'h00;
   logic [7:0] cur;
   // Unwritten option bytes read as erased FF
   assign cur = opt_addr[15:2] == OPT_BASE[15:2] ? OPT_WORD[8*opt_addr[1:0] +: 8] : 8'hFF;
   // The byte stands while the strobe is up; afterwards the bus floats to the inverse
   always @(posedge pclk) begin
      if (opt_rd) last <= cur;
   end
   assign opt_data = (opt_rd && opt_addr >= OPT_BASE && opt_addr <= OPT_TOP) ? cur : ~last;
   // A driven pin shows the block's value, otherwise the outside driver
   assign a_pins = (a_oe & a_out) | (~a_oe & a_ext);
   assign b_pins = (b_oe & b_out) | (~b_oe & b_ext);
endmodule
`default_nettype wire

/* port_and_external_interrupt_config_tb.sv */
// Purpose: Self-checking bench for the port and external interrupt block
// Assumes: Short option load count; APB master waits for pready
// Notes:   Only mismatches and the verdict are printed
`timescale 1ns/10ps
`default_nettype none
module port_and_external_interrupt_config_tb
   import pxc_pkg::*;
;
   localparam int BOOT = 20;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hold_mode = 0;
   logic [7:0] paddr = 8'h00, a_out, a_oe, a_pull, a_in, b_out, b_oe, b_pull, b_in, opt_data, irq_vec;
   logic [7:0] a_ext = 8'h3C, b_ext = 8'h04;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic [15:0] opt_addr, fetch_addr, core_addr = 16'h0000;
   logic [3:0] c_in = 4'hF, c_pull, irq_pend;
   logic pready, pslverr, c0_out, c0_oe, opt_rd, fetch_en, addr_bad, irq_req, t0_ev, wake, e;
   logic sio_dout = 0, sio_data_oe = 0, sio_clk_out = 0, sio_clk_oe = 0, pwm1_out = 0, sio_din, sio_clk_in;
   int err_total = 0, total_checks = 0, cyc = 0, t0_cnt = 0, wake_cnt = 0;
   logic [7:0] vec [4] = '{VEC_A, VEC_B, VEC_C, VEC_D};

   always #5 pclk = ~pclk;

   pxc_port_irq #(.BOOT_CYC(BOOT)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_a_pins_in(a_in), .port_a_pins_out(a_out), .port_a_pins_oe(a_oe), .port_a_pull(a_pull),
      .port_b_pins_in(b_in), .port_b_pins_out(b_out), .port_b_pins_oe(b_oe), .port_b_pull(b_pull),
      .port_c_in(c_in), .port_c_bit0_out(c0_out), .port_c_bit0_oe(c0_oe), .port_c_pull(c_pull),
      .opt_addr(opt_addr), .opt_rd(opt_rd), .opt_data(opt_data), .fetch_en(fetch_en),
      .fetch_addr(fetch_addr), .core_addr(core_addr), .core_addr_bad(addr_bad),
      .irq_pend(irq_pend), .irq_req(irq_req), .irq_vec(irq_vec), .timer0_event_in(t0_ev),
      .hold_mode(hold_mode), .hold_wake(wake), .sio_dout(sio_dout), .sio_data_oe(sio_data_oe),
      .sio_clk_out(sio_clk_out), .sio_clk_oe(sio_clk_oe), .pwm1_out(pwm1_out),
      .sio_din(sio_din), .sio_clk_in(sio_clk_in)
   );

   pxc_ext_model ext_u (
      .pclk(pclk), .opt_addr(opt_addr), .opt_rd(opt_rd), .opt_data(opt_data),
      .a_out(a_out), .a_oe(a_oe), .a_ext(a_ext), .a_pins(a_in),
      .b_out(b_out), .b_oe(b_oe), .b_ext(b_ext), .b_pins(b_in)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Event counters and hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (t0_ev === 1'b1) t0_cnt <= t0_cnt + 1;
      if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         test_done();
      end
   end

   task automatic test_done();
      if (err_total == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // APB master
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk(1'b0, 1'b1, "pready timeout");
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_boot();
      int n;
      wait_n(8);
      chk(c_pull, 4'hF, "c pull in reset");
      chk({a_pull, a_oe}, 16'h0000, "a pull/oe in reset");
      chk({b_pull, b_oe}, 16'h0000, "b pull/oe in reset");
      wait_n(2);
      presetn <= 1'b1;
      n = 0;
      while (fetch_en !== 1'b1 && n < BOOT + 10) begin
         @(posedge pclk);
         n = n + 1;
      end
      chk(n >= BOOT && n <= BOOT + 4, 1'b1, "option load length");
      chk(fetch_addr, RESET_PC, "fetch start");
      wait_n(1);
      chk(a_pull, 8'hF0, "a pull after load");
      chk(c_pull, 4'h5, "c pull after load");
      apb(1'b0, REG_STATUS, 32'h0);
      chk(q, 32'h1, "boot done flag");
   endtask

   task automatic t_map();
      core_addr <= PROG_TOP;
      wait_n(3);
      chk(addr_bad, 1'b0, "top of program space");
      core_addr <= OPT_BASE;
      wait_n(3);
      chk(addr_bad, 1'b1, "option area");
      apb(1'b0, 8'h40, 32'h0);
      chk({e, q[30:0]}, {1'b1, 31'h0000_0000}, "unmapped read");
   endtask

   task automatic t_ports();
      chk({c0_oe, c0_out}, 2'b10, "c bit0 pulled low");
      apb(1'b1, REG_PA_CTRL, 32'h0000_01A5);
      wait_n(2);
      chk(a_oe, 8'h0A, "a low nibble open drain");
      apb(1'b1, REG_PA_CTRL, 32'h0000_02A5);
      wait_n(3);
      chk(a_oe, 8'hF0, "a high nibble");
      apb(1'b0, REG_PIN_IN, 32'h0);
      chk(q[7:0], 8'hAC, "a pin levels");
      apb(1'b1, REG_PB_OUT, 32'h0);
      apb(1'b1, REG_PB_DIR, 32'h5A);
      apb(1'b1, REG_PB_PULL, 32'h3C);
      wait_n(2);
      chk(b_oe, 8'h5A, "b per bit direction");
      chk(b_pull, 8'h3C, "b pull");
      apb(1'b1, REG_PB_ALT, 32'h9);
      sio_dout <= 1'b1;
      pwm1_out <= 1'b1;
      wait_n(3);
      chk({b_out[7], b_out[0], sio_clk_in, sio_din}, 4'b1110, "b alternates");
      apb(1'b1, REG_PC_OUT, 32'h1);
      wait_n(2);
      chk({c0_oe, c0_out}, 2'b00, "c bit0 released");
   endtask

   task automatic irq_try(input int i, input int m, input logic en, input logic bef, input logic exp);
      apb(1'b1, REG_IRQ_CFG, 32'h0);
      c_in[i] <= bef;
      wait_n(6);
      apb(1'b1, REG_IRQ_PEND, 32'hF);
      apb(1'b1, REG_IRQ_CFG, (32'(en) << (CFG_EN_LSB + i)) | (32'(m) << (2 * i)));
      c_in[i] <= ~bef;
      wait_n(8);
      apb(1'b0, REG_IRQ_PEND, 32'h0);
      chk({irq_pend[i], q[i]}, {exp, exp}, "pending flag");
      if (exp) chk({irq_req, irq_vec}, {1'b1, vec[i]}, "vector");
      if (exp && m == 0) begin
         apb(1'b1, REG_IRQ_PEND, 32'h1 << i);
         apb(1'b0, REG_IRQ_PEND, 32'h0);
         chk(q[i], 1'b0, "acknowledge");
      end
   endtask

   task automatic t_irq();
      for (int i = 0; i < 4; i++) begin
         for (int m = 0; m < 4; m++) begin
            if (i < 2) irq_try(i, m, 1'b1, m[0], 1'b1);
            else irq_try(i, m, 1'b1, m == 1 || m == 2, m != 3);
         end
      end
      irq_try(0, 0, 1'b0, 1'b0, 1'b0);
      irq_try(0, 2, 1'b1, 1'b1, 1'b0);
   endtask

   task automatic filt(input logic slow, input int w, input logic exp);
      apb(1'b1, REG_IRQ_CFG, 32'h0);
      c_in[3] <= 1'b0;
      wait_n(40);
      apb(1'b1, REG_IRQ_PEND, 32'hF);
      apb(1'b1, REG_IRQ_CFG, (32'(slow) << CFG_SLOW) | 32'h800);
      c_in[3] <= 1'b1;
      wait_n(w);
      c_in[3] <= 1'b0;
      wait_n(40);
      apb(1'b0, REG_IRQ_PEND, 32'h0);
      chk(q[3], exp, "noise filter");
   endtask

   task automatic t_misc();
      filt(1'b0, 1, 1'b0);
      filt(1'b1, 10, 1'b0);
      filt(1'b1, 40, 1'b1);
      t0_cnt = 0;
      c_in[2] <= ~c_in[2];
      wait_n(4);
      c_in[2] <= ~c_in[2];
      wait_n(4);
      chk(t0_cnt, 2, "timer events");
      apb(1'b1, REG_IRQ_CFG, 32'h4);
      c_in[1] <= 1'b1;
      hold_mode <= 1'b1;
      wait_n(4);
      wake_cnt = 0;
      c_in[1] <= 1'b0;
      wait_n(4);
      hold_mode <= 1'b0;
      c_in[1] <= 1'b1;
      wait_n(2);
      c_in[1] <= 1'b0;
      wait_n(4);
      chk(wake_cnt, 1, "hold wake");
   endtask

   initial begin
      t_boot();
      t_map();
      t_ports();
      t_irq();
      t_misc();
      test_done();
   end
endmodule
`default_nettype wire
